// >>> rtl/out_clock_cfg_pkg.sv
// Constants and carrier types for the output clock configuration bank
package out_clock_cfg_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] OFS_TIMING_TRIM = 8'h1e;
    localparam logic [7:0] OFS_BUF_CONTROL = 8'h1f;
    localparam logic [7:0] OFS_PATTERN_LOW = 8'h20;
    localparam logic [7:0] OFS_PATTERN_MID = 8'h21;
    localparam logic [7:0] OFS_PATTERN_HIGH = 8'h22;
    localparam logic [7:0] OFS_DIGITAL_PATH = 8'h24;

    // ==========================================================
    // Field positions
    localparam int DELAY_SEL_LSB = 4;
    localparam int DELAY_SEL_MSB = 5;
    localparam int REDUCED_DRIVE_BIT = 7;
    localparam int SERIAL_IN_BUF_BIT = 6;
    localparam int OUT_BUF_BIT = 4;
    localparam int DOUBLE_RATE_BIT = 3;
    localparam int FEATURE_PATH_BIT = 2;
    localparam int DECIMATOR_BIT = 1;
    localparam int PATTERN_HIGH_BITS = 4;
    localparam int PATTERN_WIDTH = 20;

    // ==========================================================
    // Writable bits of the trim, buffer, pattern high and digital path registers, reserved bits cleared
    localparam logic [7:0] MASK_TIMING_TRIM = 8'h30;
    localparam logic [7:0] MASK_BUF_CONTROL = 8'hd8;
    localparam logic [7:0] MASK_PATTERN_HIGH = 8'h0f;
    localparam logic [7:0] MASK_DIGITAL_PATH = 8'h06;

    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_TIMING_TRIM = 8'h00;
    localparam logic [7:0] RST_BUF_CONTROL = 8'h10;
    localparam logic [19:0] RST_PATTERN = 20'h00000;
    localparam logic [7:0] RST_DIGITAL_PATH = 8'h00;

    // ==========================================================
    // Output clock timing shift codes and their shift in ps
    localparam logic [1:0] DELAY_NONE = 2'h0;
    localparam logic [1:0] DELAY_ADVANCE_50 = 2'h1;
    localparam logic [1:0] DELAY_LATE_50 = 2'h2;
    localparam logic [1:0] DELAY_LATE_100 = 2'h3;
    localparam logic signed [7:0] SHIFT_NONE_PS = 8'sd0;
    localparam logic signed [7:0] SHIFT_ADVANCE_50_PS = -8'sd50;
    localparam logic signed [7:0] SHIFT_LATE_50_PS = 8'sd50;
    localparam logic signed [7:0] SHIFT_LATE_100_PS = 8'sd100;

    // ==========================================================
    // Output resolution codes for the automatic bypass pattern
    localparam logic [1:0] RES_18 = 2'h0;
    localparam logic [1:0] RES_16 = 2'h1;
    localparam logic [1:0] RES_14 = 2'h2;

    // ==========================================================
    // Carrier types
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic [1:0] out_clock_delay_sel;
        logic signed [7:0] shift_ps;
        logic reduced_drive_sel;
        logic serial_clock_in_buf_on;
        logic out_clock_buf_on;
        logic single_edge_double_rate;
        logic launch_rise;
        logic launch_fall;
        logic feature_path_sel;
        logic decimator_on;
    } clock_ctl_t;

endpackage

// >>> rtl/frame_pattern_gen.sv
// Serialiser that plays a frame clock pattern one bit per cycle
`timescale 1ns/100ps
`default_nettype none
module frame_pattern_gen #(
    parameter int WIDTH = 20
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic run_i,
    input wire logic [WIDTH-1:0] pattern_i,
    output logic frame_clock_o,
    output logic frame_start_o
);

    typedef struct packed {
        logic [WIDTH-1:0] shift;
        logic [$clog2(WIDTH)-1:0] count;
        logic bit_out;
        logic start;
    } gen_state_t;

    localparam logic [$clog2(WIDTH)-1:0] LAST = ($clog2(WIDTH))'(WIDTH - 1);

    gen_state_t s_q;
    gen_state_t s_d;

    // ==========================================================
    // Next state: reload the pattern at each wrap, MSB goes first
    always_comb begin
        s_d = s_q;
        s_d.start = 1'b0;
        if (!run_i) begin
            s_d.count = '0;
            s_d.shift = pattern_i;
            s_d.bit_out = 1'b0;
        end else if (s_q.count == '0) begin
            s_d.bit_out = pattern_i[WIDTH-1];
            s_d.shift = {pattern_i[WIDTH-2:0], 1'b0};
            s_d.start = 1'b1;
            s_d.count = LAST;
        end else begin
            s_d.bit_out = s_q.shift[WIDTH-1];
            s_d.shift = {s_q.shift[WIDTH-2:0], 1'b0};
            s_d.count = s_q.count - 1'b1;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign frame_clock_o = s_q.bit_out;
    assign frame_start_o = s_q.start;

endmodule
`default_nettype wire

// >>> rtl/out_clock_cfg.sv
// Output clock and digital path configuration register bank
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module out_clock_cfg
    import out_clock_cfg_pkg::*;
#(
    parameter int SAMPLE_WIDTH = 20,
    parameter logic [19:0] AUTO_PATTERN_14 = 20'hfe000,
    parameter logic [19:0] AUTO_PATTERN_16 = 20'hff000,
    parameter logic [19:0] AUTO_PATTERN_18 = 20'hff800
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire out_clock_cfg_pkg::reg_req_t req_i,
    output logic [7:0] rdata_o,
    input wire logic companion_in_buf_en_i,
    input wire logic serial_mode_i,
    input wire logic frame_clock_run_i,
    input wire logic [1:0] out_resolution_i,
    input wire logic [SAMPLE_WIDTH-1:0] raw_sample_i,
    input wire logic [SAMPLE_WIDTH-1:0] feature_sample_i,
    output out_clock_cfg_pkg::clock_ctl_t ctl_o,
    output logic [PATTERN_WIDTH-1:0] frame_pattern_o,
    output logic [SAMPLE_WIDTH-1:0] sample_o,
    output logic frame_clock_o,
    output logic frame_start_o
);

    import out_clock_cfg_pkg::*;

    typedef struct packed {
        logic [7:0] trim;
        logic [7:0] buf_ctl;
        logic [PATTERN_WIDTH-1:0] pattern;
        logic [7:0] dig;
        logic [7:0] rdata;
        clock_ctl_t ctl;
        logic [PATTERN_WIDTH-1:0] pattern_eff;
        logic [SAMPLE_WIDTH-1:0] sample;
    } bank_state_t;

    bank_state_t s_q;
    bank_state_t s_d;
    logic bypass_mode;
    logic [PATTERN_WIDTH-1:0] auto_pattern;

    // ==========================================================
    // Decimation bypass and the automatic pattern it selects
    assign bypass_mode = !(s_q.dig[FEATURE_PATH_BIT] && s_q.dig[DECIMATOR_BIT]);

    always_comb begin
        unique case (out_resolution_i)
            RES_14: auto_pattern = AUTO_PATTERN_14;
            RES_16: auto_pattern = AUTO_PATTERN_16;
            default: auto_pattern = AUTO_PATTERN_18;
        endcase
    end

    // ==========================================================
    // Next state: register writes, read mux and derived controls
    always_comb begin
        s_d = s_q;
        s_d.rdata = 8'h00;
        // Reserved bits are masked off, so they always read zero
        if (req_i.wr) begin
            unique case (req_i.addr)
                OFS_TIMING_TRIM: s_d.trim = req_i.wdata & MASK_TIMING_TRIM;
                OFS_BUF_CONTROL: s_d.buf_ctl = req_i.wdata & MASK_BUF_CONTROL;
                OFS_PATTERN_LOW: s_d.pattern[7:0] = req_i.wdata;
                OFS_PATTERN_MID: s_d.pattern[15:8] = req_i.wdata;
                OFS_PATTERN_HIGH: begin
                    s_d.pattern[19:16] =
                        req_i.wdata[PATTERN_HIGH_BITS-1:0];
                end
                OFS_DIGITAL_PATH: s_d.dig = req_i.wdata & MASK_DIGITAL_PATH;
                default: ;
            endcase
        end
        // Read data stands in the cycle after the strobe; unmapped is zero
        if (req_i.rd) begin
            unique case (req_i.addr)
                OFS_TIMING_TRIM: s_d.rdata = s_q.trim;
                OFS_BUF_CONTROL: s_d.rdata = s_q.buf_ctl;
                OFS_PATTERN_LOW: s_d.rdata = s_q.pattern[7:0];
                OFS_PATTERN_MID: s_d.rdata = s_q.pattern[15:8];
                OFS_PATTERN_HIGH: begin
                    s_d.rdata = {4'h0, s_q.pattern[19:16]};
                end
                OFS_DIGITAL_PATH: s_d.rdata = s_q.dig;
                default: s_d.rdata = 8'h00;
            endcase
        end

        // Output clock timing trim code and its shift in ps
        s_d.ctl.out_clock_delay_sel =
            s_q.trim[DELAY_SEL_MSB:DELAY_SEL_LSB];
        unique case (s_q.trim[DELAY_SEL_MSB:DELAY_SEL_LSB])
            DELAY_NONE: s_d.ctl.shift_ps = SHIFT_NONE_PS;
            DELAY_ADVANCE_50: s_d.ctl.shift_ps = SHIFT_ADVANCE_50_PS;
            DELAY_LATE_50: s_d.ctl.shift_ps = SHIFT_LATE_50_PS;
            DELAY_LATE_100: s_d.ctl.shift_ps = SHIFT_LATE_100_PS;
        endcase

        // Buffer power and drive controls
        s_d.ctl.reduced_drive_sel = s_q.buf_ctl[REDUCED_DRIVE_BIT];
        s_d.ctl.serial_clock_in_buf_on =
            s_q.buf_ctl[SERIAL_IN_BUF_BIT] && companion_in_buf_en_i;
        s_d.ctl.out_clock_buf_on = s_q.buf_ctl[OUT_BUF_BIT];

        // Launch edges; double rate only applies in serial mode
        s_d.ctl.single_edge_double_rate =
            s_q.buf_ctl[DOUBLE_RATE_BIT];
        s_d.ctl.launch_rise = 1'b1;
        s_d.ctl.launch_fall =
            !(serial_mode_i && s_q.buf_ctl[DOUBLE_RATE_BIT]);

        // Digital path selection
        s_d.ctl.feature_path_sel = s_q.dig[FEATURE_PATH_BIT];
        s_d.ctl.decimator_on = s_q.dig[DECIMATOR_BIT];
        s_d.sample = s_q.dig[FEATURE_PATH_BIT] ?
            feature_sample_i : raw_sample_i;

        // Effective frame pattern
        s_d.pattern_eff = bypass_mode ? auto_pattern : s_q.pattern;
    end

    // ==========================================================
    // State register with reset values
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s_q <= '0;
            s_q.trim <= RST_TIMING_TRIM;
            s_q.buf_ctl <= RST_BUF_CONTROL;
            s_q.pattern <= RST_PATTERN;
            s_q.dig <= RST_DIGITAL_PATH;
            s_q.ctl.out_clock_buf_on <= 1'b1;
            s_q.ctl.launch_rise <= 1'b1;
            s_q.ctl.launch_fall <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // Frame clock serialiser
    frame_pattern_gen #(
        .WIDTH(PATTERN_WIDTH)
    ) u_frame_gen (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .run_i(frame_clock_run_i),
        .pattern_i(s_q.pattern_eff),
        .frame_clock_o(frame_clock_o),
        .frame_start_o(frame_start_o)
    );

    assign rdata_o = s_q.rdata;
    assign ctl_o = s_q.ctl;
    assign frame_pattern_o = s_q.pattern_eff;
    assign sample_o = s_q.sample;

endmodule
`default_nettype wire

// >>> sim/out_clock_cfg_properties.sv
// Assertions on the ports of the output clock configuration bank
`timescale 1ns/100ps
`default_nettype none
module out_clock_cfg_properties
    import out_clock_cfg_pkg::*;
#(
    parameter int SAMPLE_WIDTH = 20
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire out_clock_cfg_pkg::reg_req_t req_i,
    input wire logic companion_in_buf_en_i,
    input wire logic serial_mode_i,
    input wire logic frame_clock_run_i,
    input wire logic [1:0] out_resolution_i,
    input wire logic [SAMPLE_WIDTH-1:0] raw_sample_i,
    input wire logic [SAMPLE_WIDTH-1:0] feature_sample_i,
    input wire out_clock_cfg_pkg::clock_ctl_t ctl_o,
    input wire logic [19:0] frame_pattern_o,
    input wire logic [SAMPLE_WIDTH-1:0] sample_o,
    input wire logic frame_start_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // ==========================================================
    // Write strobes decoded per register
    logic w_trim;
    logic w_buf;
    logic w_dig;
    assign w_trim = req_i.wr && req_i.addr == OFS_TIMING_TRIM;
    assign w_buf = req_i.wr && req_i.addr == OFS_BUF_CONTROL;
    assign w_dig = req_i.wr && req_i.addr == OFS_DIGITAL_PATH;
    // ==========================================================
    // Controls follow written fields two edges after the strobe
    delay_code_follows_a: assert property (
        w_trim |-> ##2
        ctl_o.out_clock_delay_sel == $past(req_i.wdata[5:4], 2))
        else $error("delay code stale");
    drive_follows_a: assert property (
        w_buf |-> ##2
        ctl_o.reduced_drive_sel == $past(req_i.wdata[7], 2))
        else $error("drive stale");
    out_buf_follows_a: assert property (
        w_buf |-> ##2
        ctl_o.out_clock_buf_on == $past(req_i.wdata[4], 2))
        else $error("buffer stale");
    decim_follows_a: assert property (
        w_dig |-> ##2
        ctl_o.decimator_on == $past(req_i.wdata[1], 2))
        else $error("decimator stale");
    // Derived controls and data path
    serial_buf_gate_a: assert property (
        !companion_in_buf_en_i && $past(!companion_in_buf_en_i)
        |-> !ctl_o.serial_clock_in_buf_on)
        else $error("input buffer on alone");
    launch_edges_a: assert property (
        serial_mode_i && $past(serial_mode_i)
        |-> ctl_o.launch_fall == !ctl_o.single_edge_double_rate)
        else $error("launch edge wrong");
    frame_spacing_a: assert property (
        frame_start_o ##0 frame_clock_run_i [*8]
        |=> !frame_start_o)
        else $error("frame too short");
    auto_pattern_a: assert property (
        !$past(srst_i) && !ctl_o.feature_path_sel
        && $past(out_resolution_i) == RES_14
        |-> frame_pattern_o == 20'hfe000)
        else $error("auto pattern");
    sample_route_a: assert property (
        !$past(srst_i) |-> sample_o ==
        (ctl_o.feature_path_sel ? $past(feature_sample_i)
        : $past(raw_sample_i)))
        else $error("route");
endmodule
bind out_clock_cfg out_clock_cfg_properties #(.SAMPLE_WIDTH(SAMPLE_WIDTH)) i_props (
    .clk_i, .srst_i, .req_i, .companion_in_buf_en_i, .serial_mode_i,
    .frame_clock_run_i, .out_resolution_i, .raw_sample_i, .feature_sample_i,
    .ctl_o, .frame_pattern_o, .sample_o, .frame_start_o);
`default_nettype wire

// >>> sim/tb_out_clock_cfg.sv
// Self-checking bench for the output clock configuration bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_errors++; \
    $display("mismatch at %0t got %h exp %h", $time, (a), (e)); end end
module tb_out_clock_cfg;
    import out_clock_cfg_pkg::*;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    reg_req_t req_i = '0;
    logic companion_in_buf_en_i = 1'b0;
    logic serial_mode_i = 1'b0;
    logic frame_clock_run_i = 1'b0;
    logic [1:0] out_resolution_i = 2'h0;
    logic [19:0] raw_sample_i = 20'h12345;
    logic [19:0] feature_sample_i = 20'habcde;
    logic [7:0] rdata_o;
    clock_ctl_t ctl_o;
    logic [19:0] frame_pattern_o, sample_o;
    logic frame_clock_o, frame_start_o;
    int n_errors = 0;
    int checked = 0;
    logic [7:0] ofs [7] = '{8'h1e, 8'h1f, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24};
    logic [7:0] rst_v [7] = '{8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] all_v [7] = '{8'h30, 8'hd8, 8'hff, 8'hff, 8'h0f, 8'h00, 8'h06};
    logic [19:0] auto_v [4] = '{20'hff800, 20'hff000, 20'hfe000, 20'hff800};
    logic signed [7:0] ps_v [4] = '{8'sd0, -8'sd50, 8'sd50, 8'sd100};
    logic [19:0] pat = 20'hfe000;

    out_clock_cfg i_dut (.clk_i, .srst_i, .req_i, .rdata_o,
        .companion_in_buf_en_i, .serial_mode_i, .frame_clock_run_i,
        .out_resolution_i, .raw_sample_i, .feature_sample_i, .ctl_o,
        .frame_pattern_o, .sample_o, .frame_clock_o, .frame_start_o);

    // 200 MHz clock
    initial forever #2.5 clk_i = ~clk_i;

    // ==========================================================
    // Register port cycles and settling
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        req_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_i);
        req_i <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        req_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_i);
        req_i <= '0;
        #1 `CHK(rdata_o, e)
        @(posedge clk_i);
        #1 `CHK(rdata_o, 8'h00)
    endtask
    task automatic settle;
        repeat (2) @(posedge clk_i);
        #1;
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // ==========================================================
    // Test sequence
    initial begin
        repeat (10) @(posedge clk_i);
        srst_i <= 1'b0;
        foreach (ofs[i]) rd(ofs[i], rst_v[i]);
        `CHK(ctl_o.out_clock_buf_on, 1'b1)
        `CHK(frame_pattern_o, 20'hff800)
        foreach (ofs[i]) wr(ofs[i], all_v[i]);
        foreach (ofs[i]) rd(ofs[i], all_v[i]);
        $display("registers done");
        for (int c = 0; c < 4; c++) begin
            wr(OFS_TIMING_TRIM, {2'b00, c[1:0], 4'h0});
            settle();
            `CHK(ctl_o.out_clock_delay_sel, c[1:0])
            `CHK(ctl_o.shift_ps, ps_v[c])
        end
        $display("timing shift done");
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_i);
            companion_in_buf_en_i <= i[0];
            serial_mode_i <= i[1];
            wr(OFS_BUF_CONTROL, i[2] ? 8'hc8 : 8'h10);
            settle();
            `CHK(ctl_o.reduced_drive_sel, i[2])
            `CHK(ctl_o.serial_clock_in_buf_on, i[0] & i[2])
            `CHK(ctl_o.out_clock_buf_on, !i[2])
            `CHK(ctl_o.single_edge_double_rate, i[2])
            `CHK(ctl_o.launch_fall, !(i[1] & i[2]))
            `CHK(ctl_o.launch_rise, 1'b1)
        end
        $display("buffer control done");
        wr(OFS_DIGITAL_PATH, 8'h06);
        wr(OFS_PATTERN_LOW, 8'h00);
        wr(OFS_PATTERN_MID, 8'he0);
        wr(OFS_PATTERN_HIGH, 8'h0f);
        settle();
        `CHK(ctl_o.feature_path_sel, 1'b1)
        `CHK(sample_o, feature_sample_i)
        `CHK(frame_pattern_o, pat)
        @(posedge clk_i);
        frame_clock_run_i <= 1'b1;
        for (int b = 19; b >= 0; b--) begin
            @(posedge clk_i);
            #1 `CHK(frame_clock_o, pat[b])
            `CHK(frame_start_o, (b == 19))
        end
        @(posedge clk_i);
        #1 `CHK(frame_start_o, 1'b1)
        frame_clock_run_i <= 1'b0;
        $display("frame pattern done");
        wr(OFS_DIGITAL_PATH, 8'h02);
        for (int r = 0; r < 4; r++) begin
            @(posedge clk_i);
            out_resolution_i <= r[1:0];
            settle();
            `CHK(frame_pattern_o, auto_v[r])
        end
        `CHK(sample_o, raw_sample_i)
        `CHK(ctl_o.decimator_on, 1'b1)
        $display("bypass done");
        end_of_test();
    end
endmodule
`default_nettype wire
